// file: common/eprs_defs.vh
`ifndef EPRS_DEFS_VH
`define EPRS_DEFS_VH

// Register address on the CPU I/O port space
`define EPRS_ROUTE_ADDR 16'h1C00
// Field positions
`define EPRS_PP_HI 14
`define EPRS_PP_LO 12
`define EPRS_SP1_HI 11
`define EPRS_SP1_LO 10
`define EPRS_SP0_HI 9
`define EPRS_SP0_LO 8
// Writable bits and reset value
`define EPRS_WR_MASK 16'h7F00
`define EPRS_RESET_VAL 16'h0000
// Parallel port modes
`define EPRS_PP_LCD16 3'h0
`define EPRS_PP_SPI_GP_UART_A2 3'h1
`define EPRS_PP_LCD8_GP 3'h2
`define EPRS_PP_LCD8_SPI_A3 3'h3
`define EPRS_PP_LCD8_A2_UART 3'h4
`define EPRS_PP_LCD8_SPI_UART 3'h5
`define EPRS_PP_SPI_A2_A3_GP 3'h6
// Serial port modes
`define EPRS_SP_CARD 2'h0
`define EPRS_SP_AUDIO_GP 2'h1
`define EPRS_SP_GP 2'h2

`endif

// file: core/eprs_route_select.v
`timescale 1ns/1ps
`default_nettype none
`include "eprs_defs.vh"

// Contract
// - Bits 15 and 7:0 are reserved, read-only; writes leave them unchanged.
// - Bits 14:12 pick the parallel port mapping; code 111 reserved.
// - Mode 000 puts all 21 LCD bridge signals on the parallel port.
// - Mode 001 routes 7 SPI, 6 GPIO, 4 UART, 4 audio port 2.
// - Mode 010 routes 8 LCD pixel bits and 8 GPIO.
// - Mode 011 routes 8 LCD pixel bits, 4 SPI, 4 audio port 3.
// - Mode 100 routes 8 LCD pixel bits, 4 audio port 2, 4 UART.
// - Mode 101 routes 8 LCD pixel bits, 4 SPI, 4 UART.
// - Mode 110 routes 7 SPI, audio ports 2 and 3, 6 GPIO.
// - Bits 11:10 at 00 put memory card port 1 on serial port 1.
// - Serial port 1 mode 01 routes audio port 1 plus GPIO 11:10.
// - Serial port 1 mode 10 routes GPIO 11:6; code 11 reserved.
// - Bits 9:8 at 00 put memory card port 0 on serial port 0.
// - Serial port 0 mode 01 routes audio port 0 plus GPIO 5:4.
// - Serial port 0 mode 10 routes GPIO 5:0; code 11 reserved.
// - New routing takes effect on the CPU clock after the write.
// - Register sits at I/O port address 0x1C00.
module eprs_route_select (
  input wire clk_sys,
  input wire rstn,
  // CPU I/O port access
  input wire [15:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [15:0] io_wdata,
  output reg [15:0] io_rdata,
  // Current field values for other logic
  output wire [2:0] parallel_port_route_sel,
  output wire [1:0] serial_port1_route_sel,
  output wire [1:0] serial_port0_route_sel,
  // Parallel port pins
  input wire [20:0] pp_pin_in,
  output reg [20:0] pp_pin_out,
  output reg [20:0] pp_pin_oe,
  // LCD bridge: [15:0] data, 16 en_rd, 17 cs0, 18 cs1, 19 rw_wr, 20 rs
  input wire [20:0] lcd_out,
  input wire [20:0] lcd_oe,
  output reg [15:0] lcd_data_in,
  // SPI: 0 clk, 1 rx, 2 tx, 3 cs0, 4 cs1, 5 cs2, 6 cs3
  input wire [6:0] spi_out,
  input wire [6:0] spi_oe,
  output reg spi_rx_in,
  // UART: 0 rts, 1 cts, 2 rxd, 3 txd
  input wire [3:0] uart_out,
  input wire [3:0] uart_oe,
  output reg [3:0] uart_in,
  // Audio serial ports 2 and 3: 0 clk, 1 fs, 2 rx, 3 dx
  input wire [3:0] audio_serial_port2_out,
  input wire [3:0] audio_serial_port2_oe,
  output reg [3:0] audio_serial_port2_in,
  input wire [3:0] audio_serial_port3_out,
  input wire [3:0] audio_serial_port3_oe,
  output reg [3:0] audio_serial_port3_in,
  // General purpose pins 0..31 (only muxed ones are used)
  input wire [31:0] general_purpose_pin_out,
  input wire [31:0] general_purpose_pin_oe,
  output reg [31:0] general_purpose_pin_in,
  // Serial port 1 and its sources
  input wire [5:0] sp1_pin_in,
  output wire [5:0] sp1_pin_out,
  output wire [5:0] sp1_pin_oe,
  input wire [5:0] memory_card_port1_out,
  input wire [5:0] memory_card_port1_oe,
  output wire [5:0] memory_card_port1_in,
  input wire [3:0] audio_serial_port1_out,
  input wire [3:0] audio_serial_port1_oe,
  output wire [3:0] audio_serial_port1_in,
  // Serial port 0 and its sources
  input wire [5:0] sp0_pin_in,
  output wire [5:0] sp0_pin_out,
  output wire [5:0] sp0_pin_oe,
  input wire [5:0] memory_card_port0_out,
  input wire [5:0] memory_card_port0_oe,
  output wire [5:0] memory_card_port0_in,
  input wire [3:0] audio_serial_port0_out,
  input wire [3:0] audio_serial_port0_oe,
  output wire [3:0] audio_serial_port0_in
);

  ////////////////////////////////////////////////////////////////////////////
  // Register
  reg [15:0] external_pin_route_select_r;
  wire [15:0] external_pin_route_select_nxt;
  wire hit;
  wire [5:0] sp1_gp_in;
  wire [5:0] sp0_gp_in;

  assign hit = (io_addr == `EPRS_ROUTE_ADDR);
  // Only the three route fields take write data; reserved bits hold zero
  assign external_pin_route_select_nxt = (hit && io_wr) ?
    (io_wdata & `EPRS_WR_MASK) : external_pin_route_select_r;

  // Field updates on the write edge, so routing changes the next cycle
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      external_pin_route_select_r <= `EPRS_RESET_VAL;
    end else begin
      external_pin_route_select_r <= external_pin_route_select_nxt;
    end
  end

  // Read data registered; unmapped address reads zero
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      io_rdata <= 16'h0000;
    end else if (io_rd) begin
      io_rdata <= hit ? external_pin_route_select_r : 16'h0000;
    end
  end

  assign parallel_port_route_sel =
    external_pin_route_select_r[`EPRS_PP_HI:`EPRS_PP_LO];
  assign serial_port1_route_sel =
    external_pin_route_select_r[`EPRS_SP1_HI:`EPRS_SP1_LO];
  assign serial_port0_route_sel =
    external_pin_route_select_r[`EPRS_SP0_HI:`EPRS_SP0_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Parallel port mux. Pins 0..15 are data pins, 16 en_rd, 17..20 control.
  // Upper pins 16..20 and 0..1 follow LCD unless SPI owns the whole group.
  wire pp_spi_full;
  assign pp_spi_full = (parallel_port_route_sel == `EPRS_PP_SPI_GP_UART_A2) ||
                       (parallel_port_route_sel == `EPRS_PP_SPI_A2_A3_GP);

  // Drive select; reserved mode 111 leaves every pin undriven
  always @* begin
    pp_pin_out = 21'h000000;
    pp_pin_oe = 21'h000000;
    if (parallel_port_route_sel == `EPRS_PP_LCD16) begin
      pp_pin_out = lcd_out;
      pp_pin_oe = lcd_oe;
    end else if (parallel_port_route_sel != 3'h7) begin
      // Control and low pins: LCD or full SPI set
      if (pp_spi_full) begin
        pp_pin_out[16] = spi_out[0];
        pp_pin_oe[16] = spi_oe[0];
        pp_pin_out[1:0] = {spi_out[2], spi_out[1]};
        pp_pin_oe[1:0] = {spi_oe[2], spi_oe[1]};
        pp_pin_out[20:17] = spi_out[6:3];
        pp_pin_oe[20:17] = spi_oe[6:3];
        pp_pin_out[7:2] = general_purpose_pin_out[17:12];
        pp_pin_oe[7:2] = general_purpose_pin_oe[17:12];
      end else begin
        pp_pin_out[20:16] = lcd_out[20:16];
        pp_pin_oe[20:16] = lcd_oe[20:16];
        pp_pin_out[7:0] = lcd_out[7:0];
        pp_pin_oe[7:0] = lcd_oe[7:0];
      end
      // Upper data pins 8..15
      case (parallel_port_route_sel)
        `EPRS_PP_SPI_GP_UART_A2: begin
          pp_pin_out[15:8] = {uart_out, audio_serial_port2_out};
          pp_pin_oe[15:8] = {uart_oe, audio_serial_port2_oe};
        end
        `EPRS_PP_LCD8_GP: begin
          pp_pin_out[15:8] = {general_purpose_pin_out[31:27],
                              general_purpose_pin_out[20:18]};
          pp_pin_oe[15:8] = {general_purpose_pin_oe[31:27],
                             general_purpose_pin_oe[20:18]};
        end
        `EPRS_PP_LCD8_SPI_A3: begin
          pp_pin_out[15:8] = {audio_serial_port3_out, spi_out[2], spi_out[1],
                              spi_out[3], spi_out[0]};
          pp_pin_oe[15:8] = {audio_serial_port3_oe, spi_oe[2], spi_oe[1],
                             spi_oe[3], spi_oe[0]};
        end
        `EPRS_PP_LCD8_A2_UART: begin
          pp_pin_out[15:8] = {uart_out, audio_serial_port2_out};
          pp_pin_oe[15:8] = {uart_oe, audio_serial_port2_oe};
        end
        `EPRS_PP_LCD8_SPI_UART: begin
          pp_pin_out[15:8] = {uart_out, spi_out[2], spi_out[1],
                              spi_out[3], spi_out[0]};
          pp_pin_oe[15:8] = {uart_oe, spi_oe[2], spi_oe[1],
                             spi_oe[3], spi_oe[0]};
        end
        default: begin
          pp_pin_out[15:8] = {audio_serial_port3_out,
                              audio_serial_port2_out};
          pp_pin_oe[15:8] = {audio_serial_port3_oe, audio_serial_port2_oe};
        end
      endcase
    end
  end

  // Pin inputs back to the owning peripheral; non-owners see zero
  always @* begin
    lcd_data_in = 16'h0000;
    spi_rx_in = 1'b0;
    uart_in = 4'h0;
    audio_serial_port2_in = 4'h0;
    audio_serial_port3_in = 4'h0;
    general_purpose_pin_in = {20'h00000, sp1_gp_in, sp0_gp_in}; // GPIO 11:6 and 5:0
    case (parallel_port_route_sel)
      `EPRS_PP_LCD16: begin
        lcd_data_in = pp_pin_in[15:0];
      end
      `EPRS_PP_SPI_GP_UART_A2: begin
        spi_rx_in = pp_pin_in[0];
        general_purpose_pin_in[17:12] = pp_pin_in[7:2];
        audio_serial_port2_in = pp_pin_in[11:8];
        uart_in = pp_pin_in[15:12];
      end
      `EPRS_PP_LCD8_GP: begin
        lcd_data_in[7:0] = pp_pin_in[7:0];
        general_purpose_pin_in[20:18] = pp_pin_in[10:8];
        general_purpose_pin_in[31:27] = pp_pin_in[15:11];
      end
      `EPRS_PP_LCD8_SPI_A3: begin
        lcd_data_in[7:0] = pp_pin_in[7:0];
        spi_rx_in = pp_pin_in[10];
        audio_serial_port3_in = pp_pin_in[15:12];
      end
      `EPRS_PP_LCD8_A2_UART: begin
        lcd_data_in[7:0] = pp_pin_in[7:0];
        audio_serial_port2_in = pp_pin_in[11:8];
        uart_in = pp_pin_in[15:12];
      end
      `EPRS_PP_LCD8_SPI_UART: begin
        lcd_data_in[7:0] = pp_pin_in[7:0];
        spi_rx_in = pp_pin_in[10];
        uart_in = pp_pin_in[15:12];
      end
      `EPRS_PP_SPI_A2_A3_GP: begin
        spi_rx_in = pp_pin_in[0];
        general_purpose_pin_in[17:12] = pp_pin_in[7:2];
        audio_serial_port2_in = pp_pin_in[11:8];
        audio_serial_port3_in = pp_pin_in[15:12];
      end
      default: begin
        lcd_data_in = 16'h0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial ports; reserved code 11 leaves pins undriven
  eprs_serial_mux u_sp1 (
    .sel(serial_port1_route_sel),
    .card_out(memory_card_port1_out),
    .card_oe(memory_card_port1_oe),
    .audio_out(audio_serial_port1_out),
    .audio_oe(audio_serial_port1_oe),
    .gp_out(general_purpose_pin_out[11:6]),
    .gp_oe(general_purpose_pin_oe[11:6]),
    .pin_in(sp1_pin_in),
    .pin_out(sp1_pin_out),
    .pin_oe(sp1_pin_oe),
    .card_in(memory_card_port1_in),
    .audio_in(audio_serial_port1_in),
    .gp_in(sp1_gp_in)
  );

  eprs_serial_mux u_sp0 (
    .sel(serial_port0_route_sel),
    .card_out(memory_card_port0_out),
    .card_oe(memory_card_port0_oe),
    .audio_out(audio_serial_port0_out),
    .audio_oe(audio_serial_port0_oe),
    .gp_out(general_purpose_pin_out[5:0]),
    .gp_oe(general_purpose_pin_oe[5:0]),
    .pin_in(sp0_pin_in),
    .pin_out(sp0_pin_out),
    .pin_oe(sp0_pin_oe),
    .card_in(memory_card_port0_in),
    .audio_in(audio_serial_port0_in),
    .gp_in(sp0_gp_in)
  );

endmodule // eprs_route_select

`default_nettype wire

// file: core/eprs_serial_mux.v
`timescale 1ns/1ps
`default_nettype none
`include "eprs_defs.vh"

// One 6-signal serial port: memory card, audio serial plus 2 GPIO, or 6 GPIO
module eprs_serial_mux (
  input wire [1:0] sel,
  input wire [5:0] card_out,
  input wire [5:0] card_oe,
  input wire [3:0] audio_out,
  input wire [3:0] audio_oe,
  input wire [5:0] gp_out,
  input wire [5:0] gp_oe,
  input wire [5:0] pin_in,
  output reg [5:0] pin_out,
  output reg [5:0] pin_oe,
  output wire [5:0] card_in,
  output wire [3:0] audio_in,
  output wire [5:0] gp_in
);

  // Pin drive per mode; reserved code parks the pins undriven
  always @* begin
    case (sel)
      `EPRS_SP_CARD: begin
        pin_out = card_out;
        pin_oe = card_oe;
      end
      `EPRS_SP_AUDIO_GP: begin
        pin_out = {gp_out[5:4], audio_out};
        pin_oe = {gp_oe[5:4], audio_oe};
      end
      `EPRS_SP_GP: begin
        pin_out = gp_out;
        pin_oe = gp_oe;
      end
      default: begin
        pin_out = 6'h00;
        pin_oe = 6'h00;
      end
    endcase
  end

  // Inputs to unselected peripherals read zero so idle blocks see a quiet line
  assign card_in = (sel == `EPRS_SP_CARD) ? pin_in : 6'h00;
  assign audio_in = (sel == `EPRS_SP_AUDIO_GP) ? pin_in[3:0] : 4'h0;
  assign gp_in = (sel == `EPRS_SP_GP) ? pin_in :
                 (sel == `EPRS_SP_AUDIO_GP) ? {pin_in[5:4], 4'h0} : 6'h00;

endmodule // eprs_serial_mux

`default_nettype wire

// file: tb/eprs_far_side.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Peripherals and board pins. Each source gives a fixed pattern, all distinct except audio ports 0 and 3 (both 4'hC), so
// every route shows at the pins; quiet sources stand in for gated peripherals
module eprs_far_side (
  output logic [20:0] lcd_out,
  output logic [20:0] lcd_oe,
  output logic [6:0] spi_out,
  output logic [6:0] spi_oe,
  output logic [3:0] uart_out,
  output logic [3:0] uart_oe,
  output logic [3:0] audio_serial_port2_out,
  output logic [3:0] audio_serial_port2_oe,
  output logic [3:0] audio_serial_port3_out,
  output logic [3:0] audio_serial_port3_oe,
  output logic [31:0] general_purpose_pin_out,
  output logic [31:0] general_purpose_pin_oe,
  output logic [5:0] memory_card_port1_out,
  output logic [5:0] memory_card_port1_oe,
  output logic [3:0] audio_serial_port1_out,
  output logic [3:0] audio_serial_port1_oe,
  output logic [5:0] memory_card_port0_out,
  output logic [5:0] memory_card_port0_oe,
  output logic [3:0] audio_serial_port0_out,
  output logic [3:0] audio_serial_port0_oe,
  output logic [20:0] pp_pin_in,
  output logic [5:0] sp1_pin_in,
  output logic [5:0] sp0_pin_in
);
  // Held steady across every route change, as if clock gated
  assign {lcd_out, spi_out, uart_out, audio_serial_port2_out, audio_serial_port3_out} =
    {21'h00C35A, 7'h2D, 4'h9, 4'h6, 4'hC};
  assign {general_purpose_pin_out, memory_card_port1_out, audio_serial_port1_out} =
    {32'h5A5AA5A5, 6'h2A, 4'h3};
  assign {memory_card_port0_out, audio_serial_port0_out} = {6'h15, 4'hC};
  // Every source wants its pins; the route decides who gets them
  assign {lcd_oe, spi_oe, uart_oe, audio_serial_port2_oe, audio_serial_port3_oe} = '1;
  assign {general_purpose_pin_oe, memory_card_port1_oe, audio_serial_port1_oe} = '1;
  assign {memory_card_port0_oe, audio_serial_port0_oe} = '1;
  // Board side levels
  assign {pp_pin_in, sp1_pin_in, sp0_pin_in} = {21'h0ABCDE, 6'h19, 6'h2B};
endmodule // eprs_far_side
`default_nettype wire

// file: tb/eprs_route_select_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "eprs_defs.vh"
////////////////////////////////////////////////////////////////////////////////
module eprs_route_select_chk (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_wdata,
  input wire logic [15:0] io_rdata,
  input wire logic [2:0] parallel_port_route_sel,
  input wire logic [1:0] serial_port1_route_sel,
  input wire logic [1:0] serial_port0_route_sel,
  input wire logic [20:0] pp_pin_out,
  input wire logic [20:0] pp_pin_oe,
  input wire logic [20:0] lcd_out,
  input wire logic [20:0] lcd_oe,
  input wire logic [5:0] sp1_pin_out,
  input wire logic [5:0] memory_card_port1_out,
  input wire logic [5:0] sp0_pin_out,
  input wire logic [31:0] general_purpose_pin_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Full 16-bit decode, so a near miss address must not count as a hit
  wire hit = io_addr == `EPRS_ROUTE_ADDR;
  chk_pp_write: assert property (
    io_wr && hit |=> parallel_port_route_sel == $past(io_wdata[14:12]))
    else $error("parallel route field not loaded");
  chk_sp1_write: assert property (
    io_wr && hit |=> serial_port1_route_sel == $past(io_wdata[11:10]))
    else $error("serial port 1 field not loaded");
  chk_sp0_write: assert property (
    io_wr && hit |=> serial_port0_route_sel == $past(io_wdata[9:8]))
    else $error("serial port 0 field not loaded");
  chk_other_keep: assert property (
    io_wr && !hit |=> $stable({parallel_port_route_sel, serial_port1_route_sel,
      serial_port0_route_sel}))
    else $error("write elsewhere changed the route");
  chk_read_back: assert property (
    io_rd && hit && !io_wr |=> io_rdata == {1'h0, parallel_port_route_sel,
      serial_port1_route_sel, serial_port0_route_sel, 8'h00})
    else $error("read value wrong");
  chk_read_other: assert property (io_rd && !hit |=> io_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_lcd_full: assert property (
    parallel_port_route_sel == 3'h0 |-> pp_pin_out == lcd_out && pp_pin_oe == lcd_oe)
    else $error("full LCD route wrong");
  chk_pp_reserved: assert property (
    parallel_port_route_sel == 3'h7 |-> pp_pin_oe == 21'h000000)
    else $error("reserved code drives pins");
  chk_sp1_card: assert property (
    serial_port1_route_sel == 2'h0 |-> sp1_pin_out == memory_card_port1_out)
    else $error("card 1 route wrong");
  chk_sp0_gpio: assert property (
    serial_port0_route_sel == 2'h2 |-> sp0_pin_out == general_purpose_pin_out[5:0])
    else $error("serial port 0 gpio route wrong");
  cov_write: cover property (io_wr && hit);
  cov_reserved: cover property (parallel_port_route_sel == 3'h7);
  cov_read_other: cover property (io_rd && !hit);
endmodule // eprs_route_select_chk
bind eprs_route_select eprs_route_select_chk i_chk (.*);
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module tb_top;
  logic clk_sys, rstn, io_wr, io_rd, spi_rx_in;
  logic [15:0] io_addr, io_wdata, io_rdata, lcd_data_in;
  logic [2:0] parallel_port_route_sel;
  logic [1:0] serial_port1_route_sel, serial_port0_route_sel;
  logic [20:0] pp_pin_in, pp_pin_out, pp_pin_oe, lcd_out, lcd_oe;
  logic [6:0] spi_out, spi_oe;
  logic [3:0] uart_out, uart_oe, uart_in;
  logic [3:0] audio_serial_port2_out, audio_serial_port2_oe, audio_serial_port2_in;
  logic [3:0] audio_serial_port3_out, audio_serial_port3_oe, audio_serial_port3_in;
  logic [31:0] general_purpose_pin_out, general_purpose_pin_oe, general_purpose_pin_in;
  logic [5:0] sp1_pin_in, sp1_pin_out, sp1_pin_oe, sp0_pin_in, sp0_pin_out, sp0_pin_oe;
  logic [5:0] memory_card_port1_out, memory_card_port1_oe, memory_card_port1_in;
  logic [5:0] memory_card_port0_out, memory_card_port0_oe, memory_card_port0_in;
  logic [3:0] audio_serial_port1_out, audio_serial_port1_oe, audio_serial_port1_in;
  logic [3:0] audio_serial_port0_out, audio_serial_port0_oe, audio_serial_port0_in;
  integer errors, check_count, cycles, i;
  // Row: register value, all 21 parallel pins, serial port 1 pins, serial port 0 pins
  logic [48:0] rows [0:7];
  // Same row index, what reaches the peripherals: lcd data, spi rx, {uart, audio 2, audio 3},
  // GPIO inputs, {card 1, audio 1}, {card 0, audio 0}
  logic [80:0] rows_in [0:7];

  eprs_route_select i_dut (.*);
  eprs_far_side i_far (.*);

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Hang guard: the whole run needs about 60 cycles
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 1000) begin
      errors = errors + 1;
      report_and_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task check(input string nm, input logic [95:0] e, input logic [95:0] g);
    check_count = check_count + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One-cycle write strobe; pins are looked at just after the taking edge
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    #1;
  endtask

  // Read data is registered and holds, so one spare edge keeps this safe
  task rdchk(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("io_rdata", 32'(e), 32'(io_rdata));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: table of all routes, then the odd cases
  initial begin
    errors = 0;
    check_count = 0;
    cycles = 0;
    rstn = 1'b0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 16'h0000;
    rows = '{{16'h0100, 21'h00C35A, 6'h2A, 6'h2C}, {16'h1600, 21'h0B96AA, 6'h13, 6'h25},
             {16'h2B00, 21'h005E5A, 6'h16, 6'h00}, {16'h3C00, 21'h00CB5A, 6'h00, 6'h15},
             {16'h4100, 21'h00965A, 6'h2A, 6'h2C}, {16'h5600, 21'h009B5A, 6'h13, 6'h25},
             {16'h6B00, 21'h0BC6AA, 6'h16, 6'h00}, {16'h7C00, 21'h000000, 6'h00, 6'h15}};
    rows_in = '{{16'hBCDE, 1'h0, 12'h000, 32'h00000020, 10'h190, 10'h00B},
                {16'h0000, 1'h0, 12'hBC0, 32'h0003742B, 10'h009, 10'h000},
                {16'h00DE, 1'h0, 12'h000, 32'hB8100640, 10'h000, 10'h000},
                {16'h00DE, 1'h1, 12'h00B, 32'h00000000, 10'h000, 10'h2B0},
                {16'h00DE, 1'h0, 12'hBC0, 32'h00000020, 10'h190, 10'h00B},
                {16'h00DE, 1'h1, 12'hB00, 32'h0000042B, 10'h009, 10'h000},
                {16'h0000, 1'h0, 12'h0CB, 32'h00037640, 10'h000, 10'h000},
                {16'h0000, 1'h0, 12'h000, 32'h00000000, 10'h000, 10'h2B0}};
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    rdchk(16'h1C00, 16'h0000);
    // Reserved bits are always written as ones; they must not stick
    for (i = 0; i < 8; i = i + 1) begin
      wr(16'h1C00, rows[i][48:33] | 16'h80FF);
      check("pp_pins", 32'(rows[i][32:12]), 32'(pp_pin_out & pp_pin_oe));
      check("to_peripherals", 96'(rows_in[i]), 96'({lcd_data_in, spi_rx_in, uart_in,
        audio_serial_port2_in, audio_serial_port3_in, general_purpose_pin_in,
        memory_card_port1_in, audio_serial_port1_in, memory_card_port0_in,
        audio_serial_port0_in}));
      check("sp1_pins", 32'(rows[i][11:6]), 32'(sp1_pin_out & sp1_pin_oe));
      check("sp0_pins", 32'(rows[i][5:0]), 32'(sp0_pin_out & sp0_pin_oe));
      if (i == 1) begin
        check("uart_in", 32'(pp_pin_in[15:12]), 32'(uart_in));
        check("gp_in", 32'(sp0_pin_in), 32'(general_purpose_pin_in[5:0]));
      end
      rdchk(16'h1C00, rows[i][48:33]);
    end
    // Neighbouring address must neither load nor answer
    wr(16'h1C01, 16'hFFFF);
    rdchk(16'h1C01, 16'h0000);
    rdchk(16'h1C00, 16'h7C00);
    // Second reset in mid-run clears every field at once
    @(posedge clk_sys);
    rstn <= 1'b0;
    #1;
    check("route_sel", 32'h0, 32'({parallel_port_route_sel, serial_port1_route_sel,
      serial_port0_route_sel}));
    @(posedge clk_sys);
    rstn <= 1'b1;
    rdchk(16'h1C00, 16'h0000);
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
